// *** hw/crd_pkg.sv ***
package crd_pkg;
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RCW_W = 32;
    localparam int unsigned NUM_BUS_OUT = 5;
    localparam int unsigned NUM_UNITS = 5;
    localparam int unsigned MODE_W = 2;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_OUTPUT_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_CLOCK_CONTROL = 8'h04;
    localparam logic [7:0] OFS_LOCAL_BUS_CLOCK_CONTROL = 8'h08;
    localparam logic [7:0] OFS_CLOCK_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CLOCK_RATIOS = 8'h10;

    // reset values
    localparam logic [4:0] OUT_CTRL_RESET = 5'h00;
    localparam logic [9:0] SYS_CTRL_RESET = 10'h155;
    localparam logic [1:0] LB_CTRL_RESET = 2'h0;

    // unit slots in the system clock control register, two bits each; the bridge DMA slot uses only its low bit (full or off)
    localparam int unsigned UNIT_ETH_ONE = 0;
    localparam int unsigned UNIT_ETH_TWO = 1;
    localparam int unsigned UNIT_CRYPTO = 2;
    localparam int unsigned UNIT_USB = 3;
    localparam int unsigned UNIT_BRIDGE_DMA = 4;

    // reset configuration word low field positions
    localparam int unsigned RCW_MULT_LSB = 24;
    localparam int unsigned RCW_CORE_LSB = 16;
    localparam int unsigned RCW_MEM_MODE_BIT = 30;
    localparam int unsigned RCW_LB_MODE_BIT = 31;
    localparam logic [31:0] RCW_HARD_OPTION = 32'h0402_0000;

    // system PLL multiplier legal range
    localparam logic [3:0] MULT_MIN = 4'h2;
    localparam logic [3:0] MULT_MAX = 4'h6;

    // local bus divider field encodings
    localparam logic [1:0] LBDIV_2 = 2'h0;
    localparam logic [1:0] LBDIV_4 = 2'h1;
    localparam logic [1:0] LBDIV_8 = 2'h2;

    // status bit positions
    localparam int unsigned ST_HOST_MODE = 0;
    localparam int unsigned ST_HALVING = 1;
    localparam int unsigned ST_MULT_RESERVED = 2;
    localparam int unsigned ST_CFG_LOADED = 3;
    localparam int unsigned ST_HARD_OPTION = 4;

    typedef enum logic [1:0] {
        CRD_RATE_OFF,
        CRD_RATE_FULL,
        CRD_RATE_HALF,
        CRD_RATE_THIRD
    } crd_rate_e;
endpackage

// *** hw/crd_sync2.sv ***
`timescale 1ns/100ps
module crd_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1_r <= '0;
            sync_out <= '0;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule // crd_sync2

// *** hw/crd_ratio_div.sv ***
`timescale 1ns/100ps
module crd_ratio_div import crd_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic [MODE_W-1:0] rate_sel,
    output logic unit_enable
);
    logic [1:0] mode_r;
    logic [1:0] cnt_r;
    logic [1:0] last;
    logic at_end;

    always_comb begin
        case (mode_r)
            2'h2: last = 2'h1;
            2'h3: last = 2'h2;
            default: last = 2'h0;
        endcase
    end

    assign at_end = (cnt_r == last);

    // a new ratio is taken only at the end of a whole period, or in any cycle while off
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_r <= CRD_RATE_FULL;
        end else if (at_end || mode_r == CRD_RATE_OFF) begin
            mode_r <= rate_sel;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || at_end || mode_r == CRD_RATE_OFF) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    assign unit_enable = (mode_r != CRD_RATE_OFF) && (cnt_r == 2'h0);

    // a switch-off waits for the running period, three cycles at the most
    off_silent_a: assert property (@(posedge clock) disable iff (reset)
        (rate_sel == CRD_RATE_OFF) [*4] |-> !unit_enable)
        else $error("unit enable pulsed while off");

    third_gap_a: assert property (@(posedge clock) disable iff (reset)
        (unit_enable && mode_r == CRD_RATE_THIRD) |=> !unit_enable ##1 !unit_enable)
        else $error("third rate period cut short");
endmodule // crd_ratio_div

// *** hw/crd_top.sv ***
`timescale 1ns/100ps
module crd_top import crd_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic host_mode_strap,
    input wire logic input_halving_strap,
    input wire logic host_clock_input,
    input wire logic agent_bus_clock,
    input wire logic hard_option_strap,
    input wire logic [RCW_W-1:0] reset_config_word_low,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    output logic primary_clock_level,
    output logic sync_clock_output,
    output logic [NUM_BUS_OUT-1:0] bus_clock_output_n,
    output logic local_bus_clock_output,
    output logic [NUM_UNITS-1:0] unit_clock_enable,
    output logic [7:0] csb_multiplier,
    output logic [7:0] memory_multiplier,
    output logic [7:0] local_bus_multiplier,
    output logic [6:0] core_pll_ratio,
    output logic multiplier_reserved
);
    localparam int unsigned PIN_W = 5 + RCW_W;

    logic [PIN_W-1:0] pins_s;
    logic host_mode_s, halving_s, host_s, agent_s, hard_s;
    logic [RCW_W-1:0] rcw_s;
    logic [1:0] settle_r;
    logic cfg_loaded_r;
    logic host_mode_r, halving_r, hard_r;
    logic [3:0] system_pll_multiplier;
    logic memory_clock_mode, local_bus_clock_mode;
    logic host_d_r, host_rise, half_r, sync_nxt;
    logic [4:0] output_clock_control;
    logic [9:0] system_clock_control;
    logic [1:0] local_bus_divider, lb_div_r;
    logic [1:0] lb_cnt_r, lb_half_last;
    logic [RCW_W-1:0] rcw_pick;

    function automatic logic [MODE_W-1:0] unit_rate(input logic [9:0] ctrl, input int unsigned u);
        unit_rate = (u == UNIT_BRIDGE_DMA) ? {1'b0, ctrl[2*u]} : ctrl[2*u +: 2];
    endfunction

    function automatic logic mult_ok(input logic [3:0] f);
        mult_ok = (f >= MULT_MIN) && (f <= MULT_MAX);
    endfunction

    crd_sync2 #(.W(PIN_W)) pin_sync (
        .clock(clock),
        .reset(reset),
        .async_in({host_mode_strap, input_halving_strap, host_clock_input, agent_bus_clock,
            hard_option_strap, reset_config_word_low}),
        .sync_out(pins_s)
    );
    assign {host_mode_s, halving_s, host_s, agent_s, hard_s, rcw_s} = pins_s;

    // reset-time configuration capture once the synchronisers have filled
    assign rcw_pick = hard_s ? RCW_HARD_OPTION : rcw_s;

    always_ff @(posedge clock) begin
        if (reset) begin
            settle_r <= 2'h0;
        end else if (settle_r != 2'(SYNC_STAGES)) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_loaded_r <= 1'b0;
            host_mode_r <= 1'b0;
            halving_r <= 1'b0;
            hard_r <= 1'b0;
            system_pll_multiplier <= 4'h0;
            core_pll_ratio <= 7'h00;
            memory_clock_mode <= 1'b0;
            local_bus_clock_mode <= 1'b0;
        end else if (!cfg_loaded_r && settle_r == 2'(SYNC_STAGES)) begin
            cfg_loaded_r <= 1'b1;
            host_mode_r <= host_mode_s;
            halving_r <= halving_s;
            hard_r <= hard_s;
            system_pll_multiplier <= rcw_pick[RCW_MULT_LSB +: 4];
            core_pll_ratio <= rcw_pick[RCW_CORE_LSB +: 7];
            memory_clock_mode <= rcw_pick[RCW_MEM_MODE_BIT];
            local_bus_clock_mode <= rcw_pick[RCW_LB_MODE_BIT];
        end
    end

    // primary source and synchronisation clock
    assign host_rise = host_s && !host_d_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            host_d_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            host_d_r <= host_s;
            if (host_rise) begin
                half_r <= !half_r;
            end
        end
    end

    always_comb begin
        if (!cfg_loaded_r || !host_mode_r) begin
            sync_nxt = 1'b0;
        end else if (halving_r) begin
            sync_nxt = half_r;
        end else begin
            sync_nxt = host_s;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            primary_clock_level <= 1'b0;
            sync_clock_output <= 1'b0;
        end else begin
            primary_clock_level <= host_mode_r ? host_s : agent_s;
            sync_clock_output <= sync_nxt;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUS_OUT; gi++) begin : g_bus_out
            always_ff @(posedge clock) begin
                if (reset) begin
                    bus_clock_output_n[gi] <= 1'b0;
                end else begin
                    bus_clock_output_n[gi] <= sync_nxt && output_clock_control[gi];
                end
            end
        end
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            crd_ratio_div unit_div (
                .clock(clock),
                .reset(reset),
                .rate_sel(unit_rate(system_clock_control, gi)),
                .unit_enable(unit_clock_enable[gi])
            );
        end
    endgenerate

    // ratio report; reserved multiplier codes yield zero
    assign multiplier_reserved = cfg_loaded_r && !mult_ok(system_pll_multiplier);

    always_ff @(posedge clock) begin
        if (reset) begin
            csb_multiplier <= 8'h00;
            memory_multiplier <= 8'h00;
            local_bus_multiplier <= 8'h00;
        end else if (!mult_ok(system_pll_multiplier)) begin
            csb_multiplier <= 8'h00;
            memory_multiplier <= 8'h00;
            local_bus_multiplier <= 8'h00;
        end else begin
            csb_multiplier <= {4'h0, system_pll_multiplier} << !halving_r;
            memory_multiplier <= ({4'h0, system_pll_multiplier} << !halving_r)
                << memory_clock_mode;
            local_bus_multiplier <= ({4'h0, system_pll_multiplier} << !halving_r)
                << local_bus_clock_mode;
        end
    end

    // local bus clock output: clock taken as the local-bus controller clock
    always_comb begin
        case (lb_div_r)
            LBDIV_4: lb_half_last = 2'h1;
            LBDIV_8: lb_half_last = 2'h3;
            default: lb_half_last = 2'h0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            lb_cnt_r <= 2'h0;
            lb_div_r <= LB_CTRL_RESET;
            local_bus_clock_output <= 1'b0;
        end else if (lb_cnt_r == lb_half_last) begin
            lb_cnt_r <= 2'h0;
            local_bus_clock_output <= !local_bus_clock_output;
            if (local_bus_clock_output) begin
                lb_div_r <= local_bus_divider;
            end
        end else begin
            lb_cnt_r <= lb_cnt_r + 2'h1;
        end
    end

    // register port
    always_ff @(posedge clock) begin
        if (reset) begin
            output_clock_control <= OUT_CTRL_RESET;
            system_clock_control <= SYS_CTRL_RESET;
            local_bus_divider <= LB_CTRL_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                OFS_OUTPUT_CLOCK_CONTROL: output_clock_control <= reg_wdata[4:0];
                OFS_SYSTEM_CLOCK_CONTROL: system_clock_control <= reg_wdata[9:0];
                OFS_LOCAL_BUS_CLOCK_CONTROL: begin
                    if (reg_wdata[1:0] != 2'h3) begin
                        local_bus_divider <= reg_wdata[1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_OUTPUT_CLOCK_CONTROL: reg_rdata <= {27'h0, output_clock_control};
                OFS_SYSTEM_CLOCK_CONTROL: reg_rdata <= {22'h0, system_clock_control};
                OFS_LOCAL_BUS_CLOCK_CONTROL: reg_rdata <= {30'h0, local_bus_divider};
                OFS_CLOCK_STATUS: reg_rdata <= {27'h0, hard_r, cfg_loaded_r, multiplier_reserved,
                    halving_r, host_mode_r};
                OFS_CLOCK_RATIOS: reg_rdata <= {1'b0, core_pll_ratio, local_bus_multiplier,
                    memory_multiplier, csb_multiplier};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // checks
    host_source_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && host_mode_r) |=> primary_clock_level == $past(host_s))
        else $error("host mode primary level not host clock");

    agent_source_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && !host_mode_r) |=> primary_clock_level == $past(agent_s)
            && !sync_clock_output)
        else $error("agent mode primary level not agent clock");

    half_rate_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && host_mode_r && halving_r && host_rise) |=> ##1
            sync_clock_output != $past(sync_clock_output))
        else $error("halved sync clock missed a host edge");

    full_rate_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && host_mode_r && !halving_r) |=> sync_clock_output == $past(host_s))
        else $error("full rate sync clock does not follow host clock");

    bus_gate_a: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> (bus_clock_output_n & ~$past(output_clock_control)) == 5'h00
            && (bus_clock_output_n & ~{NUM_BUS_OUT{sync_clock_output}}) == 5'h00)
        else $error("bus clock output driven while disabled");

    csb_mult_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && $stable(cfg_loaded_r) && !multiplier_reserved) |=>
            csb_multiplier == 8'(system_pll_multiplier * (halving_r ? 1 : 2)))
        else $error("system multiple wrong");

    mem_mult_a: assert property (@(posedge clock) disable iff (reset)
        (cfg_loaded_r && !multiplier_reserved) |=>
            memory_multiplier == (memory_clock_mode ? 8'(csb_multiplier * 2) : csb_multiplier))
        else $error("memory multiple wrong");

    reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
        multiplier_reserved |=> csb_multiplier == 8'h00 && memory_multiplier == 8'h00)
        else $error("reserved multiplier code produced a clock");

    unit_default_a: assert property (@(posedge clock)
        $fell(reset) |-> system_clock_control == SYS_CTRL_RESET ##1 unit_clock_enable == 5'h1F)
        else $error("units did not start at full rate");

    config_once_a: assert property (@(posedge clock) disable iff (reset)
        $past(cfg_loaded_r) |-> $stable(system_pll_multiplier) && $stable(core_pll_ratio))
        else $error("reset configuration changed after load");

    lb_toggle_a: assert property (@(posedge clock) disable iff (reset)
        (!$past(reset) && lb_div_r == LBDIV_2 && $past(lb_div_r) == LBDIV_2) |->
            local_bus_clock_output != $past(local_bus_clock_output))
        else $error("local bus clock not toggling at divide by two");

    host_half_c: cover property (@(posedge clock) disable iff (reset)
        cfg_loaded_r && host_mode_r && halving_r && host_rise);
    agent_c: cover property (@(posedge clock) disable iff (reset)
        cfg_loaded_r && !host_mode_r && primary_clock_level);
    unit_third_c: cover property (@(posedge clock) disable iff (reset)
        unit_rate(system_clock_control, UNIT_USB) == CRD_RATE_THIRD && unit_clock_enable[3]);
endmodule // crd_top

// *** sim/crd_osc_model.sv ***
`timescale 1ns/100ps
// free-running board oscillators; both stay far below the 66 MHz input limit
module crd_osc_model #(
    parameter int HOST_HALF = 5,
    parameter int AGENT_HALF = 7
) (
    input wire logic clock,
    input wire logic host_mode,
    output logic host_clock_input,
    output logic agent_bus_clock
);
    int host_cnt = 0;
    int agent_cnt = 0;
    logic host_osc = 1'b0;
    logic agent_osc = 1'b0;

    always @(posedge clock) begin
        host_cnt <= (host_cnt == HOST_HALF - 1) ? 0 : host_cnt + 1;
        agent_cnt <= (agent_cnt == AGENT_HALF - 1) ? 0 : agent_cnt + 1;
        if (host_cnt == HOST_HALF - 1) begin
            host_osc <= ~host_osc;
        end
        if (agent_cnt == AGENT_HALF - 1) begin
            agent_osc <= ~agent_osc;
        end
    end

    // host pin tied low whenever the board is strapped as agent
    assign host_clock_input = host_mode ? host_osc : 1'b0;
    assign agent_bus_clock = agent_osc;
endmodule // crd_osc_model

// *** sim/crd_top_tb.sv ***
`timescale 1ns/100ps
module crd_top_tb import crd_pkg::*;;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic host_mode_strap = 1'b1;
    logic input_halving_strap = 1'b0;
    logic hard_option_strap = 1'b0;
    logic [31:0] reset_config_word_low = 32'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic host_clock_input, agent_bus_clock;
    logic [31:0] reg_rdata;
    logic primary_clock_level, sync_clock_output, local_bus_clock_output, multiplier_reserved;
    logic [4:0] bus_clock_output_n, unit_clock_enable, occ;
    logic [7:0] csb_multiplier, memory_multiplier, local_bus_multiplier, sig;
    logic [6:0] core_pll_ratio;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v, r;
    logic rd_d = 1'b0;
    logic hv, hm;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 15376;
    int tg[8];
    int up[5];

    always #5 clock = ~clock;

    crd_osc_model crd_osc_model_i (.clock(clock), .host_mode(host_mode_strap),
        .host_clock_input(host_clock_input), .agent_bus_clock(agent_bus_clock));

    crd_top crd_top_i (.clock(clock), .reset(reset), .host_mode_strap(host_mode_strap),
        .input_halving_strap(input_halving_strap), .host_clock_input(host_clock_input),
        .agent_bus_clock(agent_bus_clock), .hard_option_strap(hard_option_strap),
        .reset_config_word_low(reset_config_word_low), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .primary_clock_level(primary_clock_level),
        .sync_clock_output(sync_clock_output), .bus_clock_output_n(bus_clock_output_n),
        .local_bus_clock_output(local_bus_clock_output),
        .unit_clock_enable(unit_clock_enable), .csb_multiplier(csb_multiplier),
        .memory_multiplier(memory_multiplier), .local_bus_multiplier(local_bus_multiplier),
        .core_pll_ratio(core_pll_ratio), .multiplier_reserved(multiplier_reserved));

    assign sig = {local_bus_clock_output, bus_clock_output_n, sync_clock_output,
                  primary_clock_level};

    task automatic wrap_up();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // the expected word is queued when the read is launched
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    always @(posedge clock) begin
        rd_d <= reg_read;
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            samples_checked++;
            if (reg_rdata !== exp_v) begin
                error_cnt++;
                $display("[FAIL] %0t read %h expected %h", $time, reg_rdata, exp_v);
            end
        end
    end

    task automatic near(input int got, input int e, input int tol);
        samples_checked++;
        if (got < e - tol || got > e + tol) begin
            error_cnt++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, e);
        end
    endtask

    // compares the ratio outputs and the reserved flag straight at the pins
    task automatic chk_out(input logic [32:0] e);
        logic [32:0] got;
        got = {multiplier_reserved, 1'b0, core_pll_ratio, local_bus_multiplier,
               memory_multiplier, csb_multiplier};
        samples_checked++;
        if (got !== e) begin
            error_cnt++;
            $display("[FAIL] %0t outputs %h expected %h", $time, got, e);
        end
    endtask

    // counts toggles of the clock outputs and pulses of the unit enables
    task automatic window(input int n);
        logic [7:0] p;
        tg = '{default: 0};
        up = '{default: 0};
        p = sig;
        repeat (n) begin
            @(posedge clock);
            #1;
            for (int i = 0; i < 8; i++) if (sig[i] !== p[i]) tg[i]++;
            for (int i = 0; i < 5; i++) if (unit_clock_enable[i] === 1'b1) up[i]++;
            p = sig;
        end
    endtask

    // straps and reset word only change while reset is held
    task automatic do_reset(input logic m, input logic h, input logic o, input logic [31:0] w);
        @(posedge clock);
        reset <= 1'b1;
        host_mode_strap <= m;
        input_halving_strap <= h;
        hard_option_strap <= o;
        reset_config_word_low <= w;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    function automatic logic [31:0] ratios(input logic [31:0] w, input logic h);
        logic [7:0] c;
        c = (w[27:24] >= MULT_MIN && w[27:24] <= MULT_MAX) ? (8'(w[27:24]) << !h) : 8'h00;
        return {1'b0, w[22:16], c << w[31], c << w[30], c};
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        repeat (6) @(posedge clock);
        rd(OFS_OUTPUT_CLOCK_CONTROL, 32'h0);
        rd(OFS_SYSTEM_CLOCK_CONTROL, 32'(SYS_CTRL_RESET));
        rd(OFS_LOCAL_BUS_CLOCK_CONTROL, 32'h0);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0);
        window(30);
        for (int i = 0; i < 5; i++) near(up[i], 30, 0);
        for (int s = 0; s < 16; s++) begin
            r = $random(seed);
            r[27:24] = s[3:0];
            hv = 1'($random(seed));
            hm = 1'($random(seed));
            do_reset(hm, hv, 1'b0, r);
            rd(OFS_CLOCK_RATIOS, ratios(r, hv));
            chk_out({1'(s < 2 || s > 6), ratios(r, hv)});
            rd(OFS_CLOCK_STATUS, {27'h0, 2'b01, (s < 2 || s > 6), hv, hm});
        end
        r = $random(seed);
        do_reset(1'b1, 1'b1, 1'b1, r);
        rd(OFS_CLOCK_RATIOS, ratios(RCW_HARD_OPTION, 1'b1));
        chk_out({1'b0, ratios(RCW_HARD_OPTION, 1'b1)});
        wr(OFS_CLOCK_RATIOS, r);
        rd(OFS_CLOCK_RATIOS, ratios(RCW_HARD_OPTION, 1'b1));
        rd(OFS_CLOCK_STATUS, 32'h0000_001B);
        do_reset(1'b1, 1'b0, 1'b0, r);
        window(140);
        near(tg[0], 28, 2);
        near(tg[1], 28, 2);
        do_reset(1'b1, 1'b1, 1'b0, r);
        window(140);
        near(tg[1], 14, 2);
        do_reset(1'b0, 1'b0, 1'b0, r);
        window(140);
        near(tg[0], 20, 2);
        near(tg[1], 0, 0);
        do_reset(1'b1, 1'b0, 1'b0, r);
        occ = 5'($random(seed));
        wr(OFS_OUTPUT_CLOCK_CONTROL, {27'h0, occ});
        rd(OFS_OUTPUT_CLOCK_CONTROL, {27'h0, occ});
        window(140);
        for (int i = 0; i < 5; i++) near(tg[2 + i], occ[i] ? 28 : 0, occ[i] ? 3 : 0);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_SYSTEM_CLOCK_CONTROL, {22'h0, {5{c[1:0]}}});
            repeat (6) @(posedge clock);
            window(60);
            for (int u = 0; u < 4; u++) near(up[u], (c == 0) ? 0 : 60 / c, 1);
            near(up[4], c[0] ? 60 : 0, 1);
        end
        for (int k = 0; k < 3; k++) begin
            wr(OFS_LOCAL_BUS_CLOCK_CONTROL, k);
            rd(OFS_LOCAL_BUS_CLOCK_CONTROL, k);
            repeat (12) @(posedge clock);
            window(64);
            near(tg[7], 64 >> k, 2);
        end
        wr(OFS_LOCAL_BUS_CLOCK_CONTROL, 32'h3);
        rd(OFS_LOCAL_BUS_CLOCK_CONTROL, 32'h2);
        window(64);
        near(tg[7], 16, 2);
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule // crd_top_tb
